// *** rtl/dbcml_channel.v ***
// One channel's start count and minor link word with its interpretation logic.
`timescale 1ns/1ps
`include "dbcml_regs.vh"
module dbcml_channel (
  // Clock and reset.
  input wire mclk,
  input wire sys_rst,
  // Software load of the word.
  input wire wrEn,
  input wire [15:0] wrData,
  // Engine events for this channel.
  input wire minorDone,
  input wire majorDone,
  input wire halfIrqEnable,
  input wire [15:0] curIterCount,
  // Stored word and derived results.
  output wire [15:0] word,
  output wire linkReq,
  output wire [1:0] linkTarget,
  output wire cfgMismatch,
  output wire halfHit
);
  reg [15:0] word_q;
  wire linked;
  wire [14:0] startCount;
  wire [14:0] curCount;

  // No reset term: the word is undefined until software loads it.
  always @(posedge mclk)
  begin
    if (wrEn)
    begin
      // Reserved bits are dropped when the link view applies.
      word_q <= wrData[`DBCML_MLE_BIT] ? (wrData & `DBCML_LINKED_MASK) : wrData;
    end
  end

  // Field views of the same storage selected by the link enable bit.
  assign linked = word_q[`DBCML_MLE_BIT];
  assign startCount = linked ? {6'h00, word_q[`DBCML_CNT9_HI:0]}
                             : word_q[`DBCML_CNT15_HI:0];
  assign linkTarget = word_q[`DBCML_TGT_HI:`DBCML_TGT_LO];
  // Minor link is suppressed when the same loop also exhausts the major count.
  // Reset keeps the request quiet because the stored word may still be undefined.
  assign linkReq = ~sys_rst & linked & minorDone & ~majorDone;
  assign cfgMismatch = (curIterCount != word_q);
  // The current count is read in the same field view as the stored word.
  assign curCount = linked ? {6'h00, curIterCount[`DBCML_CNT9_HI:0]}
                           : curIterCount[`DBCML_CNT15_HI:0];
  assign halfHit = ~sys_rst & halfIrqEnable & (curCount == {1'b0, startCount[14:1]});
  assign word = word_q;
endmodule

// *** rtl/dbcml_regs.vh ***
// Register offsets, field positions and constants of the start count and minor link block.
`ifndef DBCML_REGS_VH
`define DBCML_REGS_VH
`define DBCML_NUM_CH 4
`define DBCML_IDX_WORD 16'h101e
`define DBCML_IDX_STRIDE 16'h0020
`define DBCML_IDX_CUR 16'h0000
`define DBCML_IDX_ERR 16'h0001
`define DBCML_MLE_BIT 15
`define DBCML_TGT_HI 10
`define DBCML_TGT_LO 9
`define DBCML_CNT9_HI 8
`define DBCML_CNT15_HI 14
`define DBCML_LINKED_MASK 16'h87ff
`define DBCML_ONE_ITER 16'h0001
`endif

// *** rtl/dbcml_top.v ***
// Four-channel start count and minor link word block with an APB register slave.
// Operation
// - Bit 15 enables linking to another channel when this channel completes a minor loop.
// - With linking on, a finished minor loop sets the start flag of the channel in bits 10-9.
// - With linking off, bits 14-0 are one 15-bit start count and there is no target.
// - A minor loop that also exhausts the major loop takes the major link instead.
// - With linking on, the start count is bits 8-0 and bits 14-11 read as zero.
// - Software loads the word equal to the current count; a mismatch flags a config error.
// - When the major count is exhausted the whole word is copied into the current count.
// - Reset leaves the word undefined, so software loads it before using the channel.
// - With the half-point enable set, the channel interrupt rises when current equals start/2.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "dbcml_regs.vh"
module dbcml_top (
  // Clock and reset.
  input wire mclk,
  input wire sys_rst,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Engine events, one bit per channel, and two major link target bits per channel.
  input wire [3:0] minorDone,
  input wire [3:0] majorDone,
  input wire [3:0] halfIrqEnable,
  input wire [3:0] majorLinkEnable,
  input wire [7:0] majorLinkTarget,
  // Results towards the engine.
  output reg [3:0] startSet_q,
  output reg [3:0] chanIrq_q,
  output reg [3:0] cfgErr_q,
  output reg [63:0] curIterCount_q
);
  // Per-channel results gathered from the channel instances.
  wire [63:0] words;
  wire [3:0] linkReq;
  wire [7:0] linkTarget;
  wire [3:0] mismatch;
  wire [3:0] halfHit;
  // Bus phase and address decode.
  wire setup;
  wire access;
  wire [31:0] busAddr;
  wire [3:0] wordHit;
  wire [3:0] curHit;
  wire errHit;
  wire [3:0] wrSel;
  wire [3:0] curSel;
  // Next values of the engine state.
  reg [3:0] startSet_d;
  reg [63:0] curIterCount_d;
  reg [3:0] cfgErr_d;
  reg [3:0] pendLoad_d;
  reg [3:0] pendLoad_q;
  // Next values of the bus answer.
  reg [31:0] prdata_d;
  reg pslverr_d;
  // Each process keeps its own loop index so no variable has two drivers.
  integer k;
  integer m;
  integer n;

  // The setup cycle is where the answer is prepared; pready follows one cycle later.
  assign setup = psel & ~penable;

  // A write lands only at the edge that samples pready high in the access phase.
  // Deferring the write to this edge costs nothing, as the slave never stalls.
  assign access = psel & penable & pready;

  // The address is widened once so every decode compares two 32-bit values.
  assign busAddr = {16'h0000, paddr};

  // The error register sits at four times its register index.
  assign errHit = (busAddr == (4 * `DBCML_IDX_ERR));

  // Four channel slices share the same bus decode and differ only in address.
  genvar i;
  generate
    for (i = 0; i < `DBCML_NUM_CH; i = i + 1)
    begin : gCh
      // Byte address of each word is four times its register index.
      assign wordHit[i] = (busAddr == (4 * (`DBCML_IDX_WORD + i * `DBCML_IDX_STRIDE)));
      assign curHit[i] = (busAddr == (4 * (`DBCML_IDX_CUR + i * `DBCML_IDX_STRIDE)));
      // Software loads of the stored word and of the current count.
      assign wrSel[i] = access & pwrite & wordHit[i];
      assign curSel[i] = access & pwrite & curHit[i];
      // One channel's word and its interpretation.
      dbcml_channel uCh (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .wrEn(wrSel[i]),
        .wrData(pwdata[15:0]),
        .minorDone(minorDone[i]),
        .majorDone(majorDone[i]),
        .halfIrqEnable(halfIrqEnable[i]),
        .curIterCount(curIterCount_q[16*i+15:16*i]),
        .word(words[16*i+15:16*i]),
        .linkReq(linkReq[i]),
        .linkTarget(linkTarget[2*i+1:2*i]),
        .cfgMismatch(mismatch[i]),
        .halfHit(halfHit[i])
      );
    end
  endgenerate

  // Start flags: minor links and, on exhaustion, major links of each channel.
  // Two channels may aim at one target; the flags simply merge.
  always @*
  begin
    startSet_d = 4'h0;
    for (k = 0; k < 4; k = k + 1)
    begin
      // Minor link, already suppressed in the channel when the major loop ends.
      if (linkReq[k])
        startSet_d[linkTarget[2*k+:2]] = 1'b1;
      // Major link of a channel whose major loop is exhausted.
      if (majorDone[k] & majorLinkEnable[k])
        startSet_d[majorLinkTarget[2*k+:2]] = 1'b1;
    end
  end

  // Next current count and configuration error of each channel.
  always @*
  begin
    // Defaults hold the counts and errors and clear the pending loads so the process assigns all outputs on every path.
    curIterCount_d = curIterCount_q;
    cfgErr_d = cfgErr_q;
    pendLoad_d = 4'h0;
    for (m = 0; m < 4; m = m + 1)
    begin
      // Exhaustion reload wins over a software write in the same cycle.
      if (majorDone[m])
        curIterCount_d[16*m+:16] = words[16*m+:16];
      else if (curSel[m])
        curIterCount_d[16*m+:16] = pwdata[15:0];
      // The compare waits one cycle after a load so both words have settled.
      pendLoad_d[m] = wrSel[m] | curSel[m];
      if (pendLoad_q[m])
        cfgErr_d[m] = mismatch[m];
    end
  end

  // Engine state; outputs come straight from these flip-flops.
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      // Reset clears engine state but never the stored words, which live in the channels.
      startSet_q <= 4'h0;
      chanIrq_q <= 4'h0;
      cfgErr_q <= 4'h0;
      pendLoad_q <= 4'h0;
      curIterCount_q <= 64'h0;
    end
    else
    begin
      startSet_q <= startSet_d;
      chanIrq_q <= halfHit;
      cfgErr_q <= cfgErr_d;
      pendLoad_q <= pendLoad_d;
      curIterCount_q <= curIterCount_d;
    end
  end

  // Read data and error response decoded from the address of the setup cycle.
  // An unmapped address answers with an error and zero data; a write to it is dropped.
  always @*
  begin
    prdata_d = 32'h00000000;
    pslverr_d = 1'b1;
    for (n = 0; n < 4; n = n + 1)
    begin
      // The stored word reads back as kept, whichever field view applies.
      if (wordHit[n])
      begin
        pslverr_d = 1'b0;
        prdata_d = {16'h0000, words[16*n+:16]};
      end
      // Current count of the channel.
      if (curHit[n])
      begin
        pslverr_d = 1'b0;
        prdata_d = {16'h0000, curIterCount_q[16*n+:16]};
      end
    end
    // Last compare result of every channel.
    if (errHit)
    begin
      pslverr_d = 1'b0;
      prdata_d = {28'h0000000, cfgErr_q};
    end
  end

  // APB answer: one access phase, pready and pslverr stand for one cycle only.
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      // No answer is pending after reset.
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (setup)
    begin
      pready <= 1'b1;
      pslverr <= pslverr_d;
      prdata <= prdata_d;
    end
    else
    begin
      // Read data is left standing; only the strobes drop.
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule

// *** sim/dbcml_chk_assertions.sv ***
// Assertion checker for the start count and minor link block.
`timescale 1ns/1ps
module dbcml_chk (
  // Clock, reset and bus.
  input logic mclk,
  input logic sys_rst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic pready,
  input logic pslverr,
  // Engine side.
  input logic [3:0] minorDone,
  input logic [3:0] majorDone,
  input logic [3:0] halfIrqEnable,
  input logic [3:0] majorLinkEnable,
  input logic [3:0] startSet_q,
  input logic [3:0] chanIrq_q,
  input logic [3:0] cfgErr_q,
  input logic [63:0] curIterCount_q
);
  // All checks share one clock and are quiet in reset.
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_bus_answer: assert property (psel && !penable |=> pready) else $error("no answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_access: assert property (pslverr |-> pready) else $error("stray error");
  a_link_cause: assert property (startSet_q != 0 |-> $past(minorDone | majorDone) != 0)
    else $error("start without loop end");
  a_major_wins: assert property (majorDone != 0 && minorDone == majorDone &&
    majorLinkEnable == 0 |=> startSet_q == 0) else $error("minor link not suppressed");
  a_count_cause: assert property ($changed(curIterCount_q) |->
    $past(majorDone != 0 || psel && pwrite)) else $error("count changed alone");
  a_irq_enable: assert property ((chanIrq_q & ~$past(halfIrqEnable)) == 0)
    else $error("irq while disabled");
  a_err_cause: assert property ($changed(cfgErr_q) |->
    $past(psel && pwrite) || $past(psel && pwrite, 2)) else $error("error without load");
  cover property (startSet_q != 0);
  cover property (chanIrq_q != 0);
  cover property (pslverr);
endmodule

// *** sim/dbcml_top_tb.sv ***
// Self-checking testbench for the start count and minor link block.
`timescale 1ns/1ps
module dbcml_top_tb;
  logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] minorDone = 0, majorDone = 0, halfIrqEnable = 0, majorLinkEnable = 0;
  logic [7:0] majorLinkTarget = 0;
  logic [3:0] startSet_q, chanIrq_q, cfgErr_q;
  logic [63:0] curIterCount_q;
  // Channel, word written, word read back.
  logic [33:0] rows [4] = '{{2'd0, 16'h0005, 16'h0005}, {2'd1, 16'hfc05, 16'h8405},
    {2'd2, 16'hffff, 16'h87ff}, {2'd3, 16'h7fff, 16'h7fff}};
  int badCount = 0, samplesChecked = 0, cyc = 0;
  always #10 mclk = ~mclk;
  dbcml_top uut (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .minorDone, .majorDone, .halfIrqEnable, .majorLinkEnable,
    .majorLinkTarget, .startSet_q, .chanIrq_q, .cfgErr_q, .curIterCount_q);
  task summarize;
    if (badCount == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input [63:0] s, e);
    samplesChecked++;
    if (s !== e)
    begin
      badCount++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  // One bus transfer; the request is held until pready is sampled high.
  task apb(input w, input [15:0] a, input [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task ev(input [3:0] mi, ma);
    @(posedge mclk);
    minorDone <= mi;
    majorDone <= ma;
    @(posedge mclk);
    minorDone <= 0;
    majorDone <= 0;
    #1;
  endtask
  // A hang ends the run as a failure.
  always @(posedge mclk)
    if (++cyc > 3000)
    begin
      badCount++;
      summarize;
    end
  initial
  begin
    repeat (20) @(posedge mclk);
    sys_rst <= 0;
    @(posedge mclk);
    #1;
    chk("outputs", {startSet_q, chanIrq_q, cfgErr_q}, 0);
    // A word sits at four times its register index 0x101e, plus 0x20 per channel.
    foreach (rows[i])
    begin
      apb(1, 16'h4078 + 16'h0080 * rows[i][33:32], {16'h0000, rows[i][31:16]});
      apb(0, 16'h4078 + 16'h0080 * rows[i][33:32], 0);
      chk("word", rd[15:0], rows[i][15:0]);
    end
    apb(1, 16'h0000, 32'h00000005);
    @(posedge mclk);
    #1;
    chk("match", cfgErr_q[0], 0);
    @(posedge mclk);
    halfIrqEnable <= 4'h3;
    apb(1, 16'h0000, 32'h00000002);
    apb(1, 16'h0080, 32'h00008402);
    repeat (2) @(posedge mclk);
    #1;
    chk("mismatch", cfgErr_q[0], 1);
    chk("half", chanIrq_q[1:0], 2'b11);
    ev(4'h2, 4'h0);
    chk("link", startSet_q, 4'h4);
    ev(4'h1, 4'h0);
    chk("nolink", startSet_q, 0);
    ev(4'h2, 4'h2);
    chk("majorend", startSet_q, 0);
    chk("reload", curIterCount_q[31:16], 16'h8405);
    @(posedge mclk);
    majorLinkEnable <= 4'h8;
    majorLinkTarget <= 8'h40;
    ev(4'h8, 4'h8);
    chk("majorlink", startSet_q, 4'h2);
    chk("reload3", curIterCount_q[63:48], 16'h7fff);
    apb(1, 16'h4178, 32'h00000001);
    apb(1, 16'h0100, 32'h00000001);
    repeat (2) @(posedge mclk);
    #1;
    chk("single", cfgErr_q[2], 0);
    apb(0, 16'h0004, 0);
    chk("errreg", rd, 32'h0000000b);
    apb(0, 16'h0080, 0);
    chk("curread", rd, 32'h00008405);
    apb(0, 16'h0010, 0);
    chk("slverr", {er, rd}, 33'h100000000);
    // Reset in mid-run clears the engine but keeps the stored words.
    @(posedge mclk);
    sys_rst <= 1;
    repeat (2) @(posedge mclk);
    sys_rst <= 0;
    @(posedge mclk);
    #1;
    chk("rstout", {startSet_q, chanIrq_q, cfgErr_q}, 0);
    chk("rstcur", curIterCount_q, 0);
    apb(0, 16'h41f8, 0);
    chk("kept", rd[15:0], 16'h7fff);
    summarize;
  end
endmodule
bind dbcml_top dbcml_chk chk (.mclk, .sys_rst, .psel, .penable, .pwrite, .pready, .pslverr,
  .minorDone, .majorDone, .halfIrqEnable, .majorLinkEnable, .startSet_q, .chanIrq_q,
  .cfgErr_q, .curIterCount_q);
